//--- ectl_pkg.sv
// Shared types and constants of the event count and timetag logger
package ectl_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 40;
    localparam int unsigned RECOVERY_NS     = 50;
    localparam int unsigned RECOVERY_CYCLES =
        (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W   = 48;
    localparam int unsigned TIME_W  = 48;
    localparam int unsigned ARM_W   = 32;
    localparam int unsigned REC_W   = 8;

    typedef enum logic [1:0] {
        ectl_single_channel_single_edge_mode,
        ectl_single_channel_dual_edge_mode,
        ectl_dual_channel_dual_edge_mode
    } ectl_mode_t;

    typedef enum logic {
        ectl_arm_every_n,
        ectl_arm_every_period
    } ectl_arm_t;

    typedef struct packed {
        logic       rise_a;
        logic       rise_b;
        logic       stop_rise;
        logic       stop_b;
        ectl_mode_t mode;
        ectl_arm_t  arm_mode;
        logic [ARM_W-1:0] arm_n;
        logic [ARM_W-1:0] arm_period;
    } ectl_cfg_t;

    typedef struct packed {
        logic              two_edge;
        logic [CNT_W-1:0]  count;
        logic [TIME_W-1:0] start_time;
        logic [TIME_W-1:0] stop_time;
    } ectl_rec_t;

endpackage : ectl_pkg

//--- ectl_chan.sv
// One channel: edge detect, continuous event counter, arming and recovery
`timescale 1ns/1ps
`default_nettype none
module ectl_chan
    import ectl_pkg::*;
#(
    parameter int unsigned CW = CNT_W,
    parameter int unsigned AW = ARM_W
) (
    input  wire logic          sys_clk,
    input  wire logic          reset_n,
    input  wire logic          run,
    input  wire logic          comp_in,
    input  wire logic          rise_sel,
    input  wire logic          arm_sel,
    input  wire logic [AW-1:0] arm_n,
    input  wire logic [AW-1:0] arm_period,
    input  wire logic          hold,
    output logic               event_p,
    output logic               tag_p,
    output logic [CW-1:0]      count
);
    typedef struct packed {
        logic          prev;
        logic [CW-1:0] count;
        logic [AW-1:0] n_cnt;
        logic [AW-1:0] t_cnt;
        logic          t_due;
        logic [1:0]    rec;
    } chan_st_t;

    chan_st_t st_reg, st_next;
    logic     edge_seen;
    logic     ready;

    always_comb begin
        st_next   = st_reg;
        edge_seen = rise_sel ? (comp_in & ~st_reg.prev) : (~comp_in & st_reg.prev);
        event_p   = run & edge_seen;
        ready     = (st_reg.rec == 2'h0) & ~hold;
        tag_p     = 1'b0;
        st_next.prev = comp_in;
        if (st_reg.rec != 2'h0) begin
            st_next.rec = st_reg.rec - 2'h1;
        end
        if (run) begin
            if (st_reg.t_cnt + 1'b1 >= arm_period) begin
                st_next.t_cnt = '0;
                st_next.t_due = 1'b1;
            end else begin
                st_next.t_cnt = st_reg.t_cnt + 1'b1;
            end
        end
        if (event_p) begin
            st_next.count = st_reg.count + 1'b1;
            if (arm_sel == ectl_arm_every_n) begin
                if (st_reg.n_cnt + 1'b1 >= arm_n) begin
                    tag_p = ready;
                    if (ready) st_next.n_cnt = '0;
                end else begin
                    st_next.n_cnt = st_reg.n_cnt + 1'b1;
                end
            end else begin
                tag_p = ready & st_reg.t_due;
                if (tag_p) st_next.t_due = 1'b0;
            end
        end
        if (tag_p) st_next.rec = 2'(RECOVERY_CYCLES);
        if (!run) begin
            st_next.n_cnt = '0;
            st_next.t_cnt = '0;
            st_next.t_due = 1'b0;
        end
        count = st_next.count;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            // Edge detector follows the pin through reset, so no false edge on release
            st_reg      <= '0;
            st_reg.prev <= comp_in;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : ectl_chan
`default_nettype wire

//--- ectl_logger.sv
// Two-channel event counter and timetag logger writing records to memory
`timescale 1ns/1ps
`default_nettype none
module ectl_logger
    import ectl_pkg::*;
#(
    parameter int unsigned DEPTH_LOG2 = 8
) (
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    input  wire logic                  run,
    input  wire ectl_cfg_t             cfg,
    input  wire logic                  comp_a,
    input  wire logic                  comp_b,
    input  wire logic                  rd_en,
    output logic                       rd_valid,
    output ectl_rec_t                  rd_data,
    output logic [DEPTH_LOG2:0]        fill,
    output logic                       overflow,
    output logic [CNT_W-1:0]           count_a,
    output logic [CNT_W-1:0]           count_b
);
    localparam int unsigned DEPTH = 1 << DEPTH_LOG2;

    typedef struct packed {
        logic [TIME_W-1:0]     tb;
        logic [DEPTH_LOG2:0]   wp;
        logic [DEPTH_LOG2:0]   rp;
        logic                  pend;
        logic [CNT_W-1:0]      p_cnt;
        logic [TIME_W-1:0]     p_time;
        logic                  ovf;
        logic [1:0]            srec;
        logic                  stop_prev;
        logic                  rvalid;
        ectl_rec_t             rdata;
    } top_st_t;

    top_st_t    st_reg, st_next;
    ectl_rec_t  mem [DEPTH];
    ectl_rec_t  wr_rec;
    logic       wr_en;
    logic       ev_a, ev_b, tag_a, tag_b;
    logic       stop_ev, stop_rise_edge;
    logic       stop_in;
    logic       hold_a;
    logic       two_edge;
    logic       full, empty;

    assign two_edge = (cfg.mode != ectl_single_channel_single_edge_mode);
    // Channel A start tags wait for the pending stop and for recovery after it
    assign hold_a   = two_edge & (st_reg.pend | (st_reg.srec != 2'h0));

    ectl_chan u_a (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .run        (run),
        .comp_in    (comp_a),
        .rise_sel   (cfg.rise_a),
        .arm_sel    (cfg.arm_mode),
        .arm_n      (cfg.arm_n),
        .arm_period (cfg.arm_period),
        .hold       (hold_a),
        .event_p    (ev_a),
        .tag_p      (tag_a),
        .count      (count_a)
    );

    ectl_chan u_b (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .run        (run),
        .comp_in    (comp_b),
        .rise_sel   (cfg.rise_b),
        .arm_sel    (cfg.arm_mode),
        .arm_n      (cfg.arm_n),
        .arm_period (cfg.arm_period),
        .hold       (1'b0),
        .event_p    (ev_b),
        .tag_p      (tag_b),
        .count      (count_b)
    );

    assign stop_in = (cfg.mode == ectl_dual_channel_dual_edge_mode) ? comp_b : comp_a;
    assign stop_rise_edge = cfg.stop_rise ? (stop_in & ~st_reg.stop_prev)
                                          : (~stop_in & st_reg.stop_prev);
    assign stop_ev = run & stop_rise_edge;

    assign full  = (st_reg.wp[DEPTH_LOG2] != st_reg.rp[DEPTH_LOG2]) &&
                   (st_reg.wp[DEPTH_LOG2-1:0] == st_reg.rp[DEPTH_LOG2-1:0]);
    assign empty = (st_reg.wp == st_reg.rp);

    always_comb begin
        st_next = st_reg;
        wr_en   = 1'b0;
        wr_rec  = '0;
        st_next.tb = st_reg.tb + 1'b1;
        st_next.stop_prev = stop_in;
        if (st_reg.srec != 2'h0) begin
            st_next.srec = st_reg.srec - 2'h1;
        end
        if (!two_edge) begin
            wr_en  = tag_a | (cfg.stop_b & tag_b);
            wr_rec.two_edge   = 1'b0;
            wr_rec.count      = tag_a ? count_a : count_b;
            wr_rec.start_time = st_reg.tb;
            st_next.pend      = 1'b0;
        end else if (!st_reg.pend) begin
            if (tag_a) begin
                st_next.pend   = 1'b1;
                st_next.p_cnt  = count_a;
                st_next.p_time = st_reg.tb;
            end
        end else if (stop_ev) begin
            wr_en   = 1'b1;
            wr_rec.two_edge   = 1'b1;
            wr_rec.count      = st_reg.p_cnt;
            wr_rec.start_time = st_reg.p_time;
            wr_rec.stop_time  = st_reg.tb;
            st_next.pend      = 1'b0;
            st_next.srec      = 2'(RECOVERY_CYCLES);
        end
        if (!run) st_next.pend = 1'b0;
        if (wr_en) begin
            if (full) st_next.ovf = 1'b1;
            else      st_next.wp = st_reg.wp + 1'b1;
        end
        if (rd_en && !empty) begin
            st_next.rp     = st_reg.rp + 1'b1;
            st_next.rvalid = 1'b1;
            st_next.rdata  = mem[st_reg.rp[DEPTH_LOG2-1:0]];
        end else begin
            st_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wr_en && !full) mem[st_reg.wp[DEPTH_LOG2-1:0]] <= wr_rec;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            // Stop edge detector tracks the pin during reset
            st_reg           <= '0;
            st_reg.stop_prev <= stop_in;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_valid = st_reg.rvalid;
    assign rd_data  = st_reg.rdata;
    assign fill     = st_reg.wp - st_reg.rp;
    assign overflow = st_reg.ovf;
endmodule : ectl_logger
`default_nettype wire

//--- ectl_monitor.sv
// Port assertions of the event logger
`timescale 1ns/1ps
`default_nettype none
module ectl_monitor
    import ectl_pkg::*;
#(
    parameter int unsigned DEPTH_LOG2 = 8
) (
    input wire logic                sys_clk,
    input wire logic                reset_n,
    input wire logic                run,
    input wire ectl_cfg_t           cfg,
    input wire logic                comp_a,
    input wire logic                comp_b,
    input wire logic                rd_en,
    input wire logic                rd_valid,
    input wire ectl_rec_t           rd_data,
    input wire logic [DEPTH_LOG2:0] fill,
    input wire logic                overflow,
    input wire logic [CNT_W-1:0]    count_a,
    input wire logic [CNT_W-1:0]    count_b
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_cnt_a; count_a - $past(count_a) <= 1; endproperty
    a_cnt_a: assert property (p_cnt_a) else $error("count_a jumped");
    property p_cnt_b; count_b - $past(count_b) <= 1; endproperty
    a_cnt_b: assert property (p_cnt_b) else $error("count_b jumped");
    property p_rd_cause; rd_valid |-> $past(rd_en); endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("rd_valid without read");
    property p_rd_hold; !rd_valid |-> $stable(rd_data); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("rd_data moved");
    property p_fill_drop; fill < $past(fill) |-> $past(rd_en); endproperty
    a_fill_drop: assert property (p_fill_drop) else $error("fill fell without read");
    property p_fill_max; fill <= (1 << DEPTH_LOG2); endproperty
    a_fill_max: assert property (p_fill_max) else $error("fill above depth");
    property p_ovf; $past(overflow) |-> overflow; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow cleared");
    property p_recov;
        cfg.mode == ectl_single_channel_single_edge_mode && !cfg.stop_b && fill > $past(fill)
            |=> fill <= $past(fill);
    endproperty
    a_recov: assert property (p_recov) else $error("tag inside recovery");
    c_read: cover property (rd_valid);
    c_ovf: cover property ($rose(overflow));
    c_count: cover property (count_a != $past(count_a));
    c_two: cover property (rd_valid && rd_data.two_edge);
endmodule : ectl_monitor
bind ectl_logger ectl_monitor #(.DEPTH_LOG2(DEPTH_LOG2)) i_mon (.sys_clk(sys_clk),
    .reset_n(reset_n), .run(run), .cfg(cfg), .comp_a(comp_a), .comp_b(comp_b),
    .rd_en(rd_en), .rd_valid(rd_valid), .rd_data(rd_data), .fill(fill),
    .overflow(overflow), .count_a(count_a), .count_b(count_b));
`default_nettype wire

//--- ectl_comp_src.sv
// Comparator output model: square waves on both channels
`timescale 1ns/1ps
`default_nettype none
module ectl_comp_src (
    input  wire logic       sys_clk,
    input  wire logic [7:0] half_a,
    input  wire logic [7:0] half_b,
    output logic            comp_a,
    output logic            comp_b
);
    int ca = 0;
    int cb = 0;
    initial begin
        comp_a = 1'b0;
        comp_b = 1'b0;
    end
    always @(posedge sys_clk) begin
        #1;
        ca = (half_a == 0) ? 0 : ca + 1;
        cb = (half_b == 0) ? 0 : cb + 1;
        if (half_a != 0 && ca >= half_a) begin
            comp_a = !comp_a;
            ca = 0;
        end
        if (half_b != 0 && cb >= half_b) begin
            comp_b = !comp_b;
            cb = 0;
        end
    end
endmodule : ectl_comp_src
`default_nettype wire

//--- ectl_tb.sv
// Self-checking testbench of the event logger
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ectl_pkg::*;
    logic             sys_clk, reset_n, run, comp_a, comp_b, rd_en, rd_valid, overflow;
    logic [7:0]       half_a, half_b;
    logic [2:0]       fill;
    logic [CNT_W-1:0] count_a, count_b;
    logic             pa, pb;
    ectl_cfg_t        cfg;
    ectl_rec_t        rd_data;
    int               ra, fb, miscompares = 0, samples_checked = 0;
    ectl_logger #(.DEPTH_LOG2(2)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .run(run),
        .cfg(cfg), .comp_a(comp_a), .comp_b(comp_b), .rd_en(rd_en), .rd_valid(rd_valid),
        .rd_data(rd_data), .fill(fill), .overflow(overflow), .count_a(count_a),
        .count_b(count_b));
    ectl_comp_src i_src (.sys_clk(sys_clk), .half_a(half_a), .half_b(half_b),
        .comp_a(comp_a), .comp_b(comp_b));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = !sys_clk;
    end
    always @(posedge sys_clk) begin
        if (reset_n && run) begin
            ra += (comp_a && !pa) ? 1 : 0;
            fb += (!comp_b && pb) ? 1 : 0;
        end
        pa = comp_a;
        pb = comp_b;
    end
    task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic go(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : go
    task automatic clr();
        reset_n = 1'b0;
        run = 1'b0;
        go(6);
        reset_n = 1'b1;
        run = 1'b1;
        ra = 0;
        fb = 0;
        chk("fill_rst", 0, fill);
        chk("count_rst", 0, count_a);
    endtask : clr
    task automatic rd(output ectl_rec_t r);
        rd_en = 1'b1;
        go(1);
        chk("rd_valid", 1, rd_valid);
        r = rd_data;
        rd_en = 1'b0;
        go(1);
    endtask : rd
    task automatic t_count();
        ectl_rec_t r;
        cfg.arm_n = 32'h3;
        half_a = 8'h4;
        half_b = 8'h3;
        go(80);
        half_a = 8'h0;
        half_b = 8'h0;
        go(4);
        chk("count_a", ra, count_a);
        chk("count_b", fb, count_b);
        chk("fill", ra / 3, fill);
        for (int i = 1; i <= ra / 3; i++) begin
            rd(r);
            chk("count", 3 * i, r.count);
            chk("two_edge", 0, r.two_edge);
        end
    endtask : t_count
    task automatic t_full();
        ectl_rec_t r;
        clr();
        cfg.arm_n = 32'h1;
        half_a = 8'h2;
        go(60);
        half_a = 8'h0;
        go(4);
        chk("overflow", 1, overflow);
        chk("fill_full", 4, fill);
        repeat (4) rd(r);
        go(1);
        chk("fill_empty", 0, fill);
    endtask : t_full
    task automatic t_two();
        ectl_rec_t r;
        clr();
        cfg.mode = ectl_single_channel_dual_edge_mode;
        half_a = 8'h5;
        go(30);
        half_a = 8'h0;
        go(12);
        rd(r);
        chk("two_edge", 1, r.two_edge);
        chk("width", 5, r.stop_time - r.start_time);
        chk("start_count", 1, r.count);
        clr();
        cfg.mode = ectl_dual_channel_dual_edge_mode;
        half_a = 8'h5;
        half_b = 8'h5;
        go(30);
        half_a = 8'h0;
        half_b = 8'h0;
        go(12);
        rd(r);
        chk("ti2_two_edge", 1, r.two_edge);
        chk("ti2_width", 1, (r.stop_time - r.start_time) >= 1 &&
            (r.stop_time - r.start_time) <= 10);
        chk("ti2_count", 1, r.count);
    endtask : t_two
    task automatic t_period();
        clr();
        cfg.mode = ectl_single_channel_single_edge_mode;
        cfg.arm_mode = ectl_arm_every_period;
        cfg.arm_period = 32'h1e;
        half_a = 8'h2;
        go(100);
        half_a = 8'h0;
        go(4);
        chk("period_tags", 3, fill);
        chk("period_ovf", 0, overflow);
    endtask : t_period
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end
    initial begin
        reset_n = 1'b0;
        run = 1'b0;
        rd_en = 1'b0;
        half_a = 8'h0;
        half_b = 8'h0;
        cfg = '0;
        cfg.rise_a = 1'b1;
        clr();
        t_count();
        t_full();
        t_two();
        t_period();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
